// File: bench/aar_action_assertions.sv
// Purpose: Port checks for the entry action block
// Assumes: Shadow bytes follow writes seen at the ports
// Notes: Bound to every aar_action instance
`timescale 1ns/1ns
`default_nettype none
module aar_action_chk #(
    parameter [3:0] PORT_NUM = 4'h1
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [7:0] i_table_sel,
    input wire logic [7:0] i_byte_offset,
    input wire logic i_data_wr,
    input wire logic i_data_rd,
    input wire logic [7:0] i_data_wdata,
    input wire logic [7:0] o_data_rdata,
    input wire logic i_match,
    input wire logic [1:0] i_match_mode_setting,
    input wire logic [1:0] i_entry_enable_setting,
    input wire logic [2:0] i_qos_priority,
    input wire logic [4:0] i_lookup_map,
    input wire logic [2:0] o_frame_priority,
    input wire logic o_remark_enable,
    input wire logic [1:0] o_remark_value,
    input wire logic [4:0] o_forward_map,
    input wire logic o_result_valid,
    input wire logic [15:0] o_cascade_bitmap,
    input wire logic o_count_event
);
    default clocking dcb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    logic [7:0] act_q;
    logic [7:0] map_q;
    wire sel_ok = i_table_sel[7:5] == 3'h2 && i_table_sel[3:0] == PORT_NUM;
    wire mt = i_match && !(i_match_mode_setting == 2'h1 && i_entry_enable_setting == 2'h0);
    // Shadow bytes, so mode checks need no internal signals
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            {act_q, map_q} <= 16'h0000;
        else if (i_data_wr && sel_ok && i_byte_offset == 8'h0A)
            act_q <= i_data_wdata;
        else if (i_data_wr && sel_ok && i_byte_offset == 8'h0B)
            map_q <= i_data_wdata;
    end
    sequence s_wr_hi;
        i_data_wr && sel_ok && i_byte_offset == 8'h0C;
    endsequence
    sequence s_rd_map;
        i_data_rd && sel_ok && i_byte_offset == 8'h0B;
    endsequence
    valid_follow_a: assert property (i_match |=> o_result_valid)
        else $error("no result");
    hold_out_a: assert property (!i_match |=> $stable(o_forward_map))
        else $error("map moved");
    map_none_a: assert property (mt && map_q[6:5] == 2'h0 |=> o_forward_map == $past(i_lookup_map))
        else $error("mode 00");
    map_or_a: assert property (mt && map_q[6:5] == 2'h1 |=>
        o_forward_map == ($past(i_lookup_map) | $past(map_q[4:0]))) else $error("mode 01");
    map_and_a: assert property (mt && map_q[6:5] == 2'h2 |=>
        o_forward_map == ($past(i_lookup_map) & $past(map_q[4:0]))) else $error("mode 10");
    map_repl_a: assert property (mt && map_q[6:5] == 2'h3 |=> o_forward_map == $past(map_q[4:0]))
        else $error("mode 11");
    prio_repl_a: assert property (mt && act_q[7:6] == 2'h3 |=> o_frame_priority == $past(act_q[5:3]))
        else $error("prio 11");
    cascade_hi_a: assert property (s_wr_hi |=> ##1 o_cascade_bitmap[15:8] == $past(i_data_wdata, 2))
        else $error("cascade");
    rd_mask_a: assert property (s_rd_map |=> o_data_rdata == ($past(map_q) & 8'h7F))
        else $error("bit 7");
endmodule // aar_action_chk
bind aar_action aar_action_chk #(.PORT_NUM(PORT_NUM)) i_chk (.*);
`default_nettype wire

// File: bench/aar_far_model.sv
// Purpose: Far-side QoS and lookup source for match frames
// Assumes: One frame per send request, one cycle later
// Notes: Idle lines show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module aar_far_model (
    input wire logic i_clk,
    input wire logic i_send,
    input wire logic [2:0] i_qos,
    input wire logic [4:0] i_map,
    output logic o_match,
    output logic [2:0] o_qos_priority,
    output logic [4:0] o_lookup_map
);
    // Toggle idle lines so stale values never look valid
    always @(posedge i_clk)
    begin
        o_match <= i_send;
        o_qos_priority <= i_send ? i_qos : ~o_qos_priority;
        o_lookup_map <= i_send ? i_map : ~o_lookup_map;
    end
    initial
        {o_match, o_qos_priority, o_lookup_map} = 9'h000;
endmodule // aar_far_model
`default_nettype wire

// File: bench/tb_top.sv
// Purpose: Self-checking bench for the entry action block
// Assumes: Entry sits in table 010, port 1
// Notes: Expected values come from a byte model kept here
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic i_clk, i_rstn, i_data_wr, i_data_rd, snd;
    logic [7:0] i_table_sel, i_byte_offset, i_data_wdata, a, b;
    logic [1:0] i_match_mode_setting, i_entry_enable_setting;
    logic [2:0] qv;
    logic [4:0] mv;
    wire i_match, o_remark_enable, o_result_valid, o_count_event;
    wire [2:0] i_qos_priority, o_frame_priority;
    wire [4:0] i_lookup_map, o_forward_map;
    wire [1:0] o_remark_value;
    wire [7:0] o_data_rdata;
    wire [15:0] o_cascade_bitmap;
    logic [7:0] m [10:13];
    int failures, samples_checked, n;
    // Clock, 50 ns period
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    aar_action i_dut (.*);
    aar_far_model i_far (.i_clk(i_clk), .i_send(snd), .i_qos(qv), .i_map(mv),
        .o_match(i_match), .o_qos_priority(i_qos_priority), .o_lookup_map(i_lookup_map));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Byte write; the model follows only for our table and port
    task automatic wrb(input logic [7:0] s, o, d);
        @(posedge i_clk);
        {i_table_sel, i_byte_offset, i_data_wdata} <= {s, o, d};
        i_data_wr <= 1'b1;
        @(posedge i_clk);
        i_data_wr <= 1'b0;
        if (s == 8'h41 && o >= 8'h0A && o <= 8'h0D)
            m[o] = (o == 8'h0B) ? d & 8'h7F : d;
    endtask
    task automatic rdb(input logic [7:0] o, e);
        @(posedge i_clk);
        {i_table_sel, i_byte_offset} <= {8'h41, o};
        i_data_rd <= 1'b1;
        @(posedge i_clk);
        i_data_rd <= 1'b0;
        @(negedge i_clk);
        chk(o_data_rdata, e);
    endtask
    // One frame; the result lands one cycle after the match
    task automatic frm(input logic [2:0] q, input logic [4:0] l, input logic cu, e);
        logic [1:0] p;
        logic [2:0] v, x;
        logic [4:0] y;
        p = cu ? 2'h0 : m[10][7:6];
        v = m[10][5:3];
        x = p == 2'h0 ? q : p == 2'h1 ? (v > q ? v : q) : p == 2'h2 ? (v < q ? v : q) : v;
        case (cu ? 2'h0 : m[11][6:5])
            2'h0: y = l;
            2'h1: y = m[11][4:0] | l;
            2'h2: y = m[11][4:0] & l;
            default: y = m[11][4:0];
        endcase
        @(posedge i_clk);
        {snd, qv, mv} <= {1'b1, q, l};
        @(posedge i_clk);
        snd <= 1'b0;
        @(posedge i_clk);
        @(negedge i_clk);
        chk(o_result_valid, 1'b1);
        chk(o_frame_priority, x);
        chk(o_forward_map, y);
        chk({o_remark_enable, o_remark_value}, cu ? 3'h0 : {m[10][2], m[10][2] ? m[10][1:0] : 2'h0});
        chk(o_count_event, e);
    endtask
    initial
    begin
        void'($urandom(12));
        {i_rstn, i_data_wr, i_data_rd, snd} = 4'h0;
        {i_table_sel, i_byte_offset, i_data_wdata} = 24'h410000;
        {i_match_mode_setting, i_entry_enable_setting, qv, mv} = 12'h000;
        foreach (m[k]) m[k] = 8'h00;
        repeat (16) @(posedge i_clk);
        i_rstn <= 1'b1;
        for (int k = 10; k < 14; k++) rdb(k[7:0], 8'h00);
        for (int k = 10; k < 14; k++)
        begin
            wrb(8'h41, k[7:0], 8'($urandom));
            rdb(k[7:0], m[k]);
        end
        chk(o_cascade_bitmap, {m[12], m[13]});
        wrb(8'h42, 8'h0C, ~m[12]);
        wrb(8'h21, 8'h0D, ~m[13]);
        rdb(8'h0E, 8'h00);
        chk(o_cascade_bitmap, {m[12], m[13]});
        // Every priority mode against every map mode
        for (int i = 0; i < 16; i++)
        begin
            a = 8'($urandom);
            b = 8'($urandom);
            wrb(8'h41, 8'h0A, {i[1:0], a[5:0]});
            wrb(8'h41, 8'h0B, {b[7], i[3:2], b[4:0]});
            frm(3'($urandom), 5'($urandom), 1'b0, 1'b0);
        end
        // Counter use, counting up to a limit of two
        @(posedge i_clk);
        i_match_mode_setting <= 2'h1;
        wrb(8'h41, 8'h0A, 8'h00);
        wrb(8'h41, 8'h0B, 8'h28);
        frm(3'h5, 5'h0A, 1'b1, 1'b0);
        frm(3'h2, 5'h15, 1'b1, 1'b1);
        // Counter use, counting down two microseconds from the first match
        wrb(8'h41, 8'h0B, 8'h20);
        frm(3'h3, 5'h11, 1'b1, 1'b0);
        n = 0;
        while (!o_count_event && n < 60)
        begin
            @(negedge i_clk);
            n++;
        end
        chk(n >= 21 && n <= 40, 1'b1);
        results();
    end
    // Cut a hang short well past the expected run length
    initial
    begin
        #2000000;
        failures++;
        results();
    end
endmodule // tb_top
`default_nettype wire

// File: design/aar_action.v
// Purpose: Action and cascade bytes of one access-list entry, with apply logic
// Assumes: 20 MHz clock; table select, offset and data strobes come from
//          the switch register bank on the same clock
// Notes: Counter use borrows the port map bits as a setup word, so the
//        priority, remark and map actions pass through while it is on.
//        Read data is registered and holds until the next read strobe.
//        The time base runs free, so the first down-count step may come
//        early by up to one unit; a user needing exact spans adds one.
//        Bit 4 is shared between the count limit and the unit choice.
`timescale 1ns/1ns
`default_nettype none
`include "aar_map.vh"

module aar_action #(
    parameter [3:0] PORT_NUM = 4'h1
) (
    input wire i_clk,
    input wire i_rstn,
    input wire [7:0] i_table_sel,
    input wire [7:0] i_byte_offset,
    input wire i_data_wr,
    input wire i_data_rd,
    input wire [7:0] i_data_wdata,
    output reg [7:0] o_data_rdata,
    input wire i_match,
    input wire [1:0] i_match_mode_setting,
    input wire [1:0] i_entry_enable_setting,
    input wire [2:0] i_qos_priority,
    input wire [4:0] i_lookup_map,
    output reg [2:0] o_frame_priority,
    output reg o_remark_enable,
    output reg [1:0] o_remark_value,
    output reg [4:0] o_forward_map,
    output reg o_result_valid,
    output reg [15:0] o_cascade_bitmap,
    output reg o_count_event
);

    // ************************************************************
    // Indirect register bytes
    // ************************************************************
    reg [7:0] prio_byte_reg;
    reg [7:0] map_byte_reg;
    reg [7:0] rs_hi_reg;
    reg [7:0] rs_lo_reg;
    wire sel_hit;
    wire [3:0] off;
    wire [2:0] sel_table;
    wire [3:0] sel_port;
    wire [3:0] off_page;

    // Select and offset fields pulled apart so each compare reads plainly
    assign sel_table = i_table_sel[`AAR_SEL_TBL_HI:`AAR_SEL_TBL_LO];
    assign sel_port = i_table_sel[`AAR_SEL_PORT_HI:`AAR_SEL_PORT_LO];
    assign off_page = i_byte_offset[`AAR_OFF_PAGE_HI:`AAR_OFF_PAGE_LO];

    // Only this port's list table is reachable; other pages alias nothing
    assign sel_hit = (sel_table == `AAR_SEL_TABLE_ACL)
        && (sel_port == PORT_NUM)
        && (off_page == `AAR_OFF_PAGE_ZERO);
    assign off = i_byte_offset[`AAR_OFF_IDX_HI:`AAR_OFF_IDX_LO];

    // Byte writes through the data register
    // Match-field bytes live elsewhere, so their offsets fall to default
    // Bit 7 of the map byte is dropped on the way in, not on the way out
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            prio_byte_reg <= `AAR_BYTE_RST;
            map_byte_reg <= `AAR_BYTE_RST;
            rs_hi_reg <= `AAR_BYTE_RST;
            rs_lo_reg <= `AAR_BYTE_RST;
        end
        else if (i_data_wr && sel_hit)
        begin
            case (off)
                `AAR_OFF_PRIORITY: prio_byte_reg <= i_data_wdata;
                `AAR_OFF_PORT_MAP: map_byte_reg <= i_data_wdata & `AAR_PORT_MAP_MASK;
                `AAR_OFF_CASCADE_BITMAP_HI: rs_hi_reg <= i_data_wdata;
                `AAR_OFF_CASCADE_BITMAP_LO: rs_lo_reg <= i_data_wdata;
                default: ;
            endcase
        end
    end

    // Read data registered; unmapped offsets read zero
    // Registering costs a cycle but keeps the output free of select glitches
    // The byte holds between reads, so slow software may sample late
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_data_rdata <= `AAR_BYTE_RST;
        else if (i_data_rd)
        begin
            if (!sel_hit)
                o_data_rdata <= `AAR_BYTE_RST;
            else
            begin
                case (off)
                    `AAR_OFF_PRIORITY: o_data_rdata <= prio_byte_reg;
                    `AAR_OFF_PORT_MAP: o_data_rdata <= map_byte_reg;
                    `AAR_OFF_CASCADE_BITMAP_HI: o_data_rdata <= rs_hi_reg;
                    `AAR_OFF_CASCADE_BITMAP_LO: o_data_rdata <= rs_lo_reg;
                    default: o_data_rdata <= `AAR_BYTE_RST;
                endcase
            end
        end
    end

    // ************************************************************
    // Field views
    // ************************************************************
    wire [1:0] priority_select_mode = prio_byte_reg[`AAR_PM_HI:`AAR_PM_LO];
    wire [2:0] entry_prio = prio_byte_reg[`AAR_P_HI:`AAR_P_LO];
    wire remark_enable = prio_byte_reg[`AAR_RPE_BIT];
    wire [1:0] remark_value = prio_byte_reg[`AAR_RP_HI:`AAR_RP_LO];
    wire [1:0] map_combine_mode = map_byte_reg[`AAR_MM_HI:`AAR_MM_LO];
    wire [4:0] entry_map = map_byte_reg[`AAR_FWD_HI:`AAR_FWD_LO];
    // Counter limit spans the whole priority byte and map bits 6:4
    // Bit 4 doubles as the unit choice, so odd limits imply milliseconds
    wire [10:0] cnt_limit = {prio_byte_reg, map_byte_reg[`AAR_MM_HI:`AAR_MM_LO],
        map_byte_reg[`AAR_FWD_HI]};
    // Cascade bitmap view, high byte first
    wire [15:0] cascade_bitmap = {rs_hi_reg, rs_lo_reg};
    // Counter use only for one exact pair of settings
    wire counter_use = (i_match_mode_setting == `AAR_MD_COUNTER)
        && (i_entry_enable_setting == `AAR_ENB_COUNTER);

    // Priority choice per mode
    // Equal values keep the classification result in modes 01 and 10,
    // since neither strictly greater nor strictly smaller holds
    function [2:0] aar_pick_prio;
        input [1:0] mode;
        input [2:0] ent;
        input [2:0] qos;
        begin
            case (mode)
                `AAR_MODE_NONE: aar_pick_prio = qos;
                `AAR_MODE_HIGHER: aar_pick_prio = (ent > qos) ? ent : qos;
                `AAR_MODE_LOWER: aar_pick_prio = (ent < qos) ? ent : qos;
                `AAR_MODE_REPLACE: aar_pick_prio = ent;
                default: aar_pick_prio = qos;
            endcase
        end
    endfunction

    // Forwarding map combine per mode
    // AND mode can give an empty map, which drops the frame downstream
    function [4:0] aar_pick_map;
        input [1:0] mode;
        input [4:0] ent;
        input [4:0] lut;
        begin
            case (mode)
                `AAR_MODE_NONE: aar_pick_map = lut;
                `AAR_MODE_HIGHER: aar_pick_map = ent | lut;
                `AAR_MODE_LOWER: aar_pick_map = ent & lut;
                `AAR_MODE_REPLACE: aar_pick_map = ent;
                default: aar_pick_map = lut;
            endcase
        end
    endfunction

    // One step up of the match counter, wrapping at the word width
    function [10:0] aar_step_up;
        input [10:0] val;
        begin
            aar_step_up = val + `AAR_CNT_ONE;
        end
    endfunction

    // One step down of the match counter
    function [10:0] aar_step_down;
        input [10:0] val;
        begin
            aar_step_down = val - `AAR_CNT_ONE;
        end
    endfunction

    // ************************************************************
    // Match result, one cycle after the match strobe; cascade bitmap registered every cycle
    // ************************************************************
    // In counter use the map bits are a setup word, so forwarding is left alone
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_frame_priority <= `AAR_PRIO_RST;
            o_remark_enable <= 1'b0;
            o_remark_value <= `AAR_RP_RST;
            o_forward_map <= `AAR_FWD_RST;
            o_result_valid <= 1'b0;
            o_cascade_bitmap <= `AAR_BITMAP_RST;
        end
        else
        begin
            o_result_valid <= i_match;
            o_cascade_bitmap <= cascade_bitmap;
            if (i_match)
            begin
                if (counter_use)
                begin
                    o_frame_priority <= i_qos_priority;
                    o_remark_enable <= 1'b0;
                    o_remark_value <= `AAR_RP_RST;
                    o_forward_map <= i_lookup_map;
                end
                else
                begin
                    o_frame_priority <= aar_pick_prio(priority_select_mode, entry_prio,
                        i_qos_priority);
                    o_remark_enable <= remark_enable;
                    o_remark_value <= remark_enable ? remark_value : `AAR_RP_RST;
                    o_forward_map <= aar_pick_map(map_combine_mode, entry_map,
                        i_lookup_map);
                end
            end
        end
    end

    // ************************************************************
    // Match counter and time base
    // ************************************************************
    // The counter runs only while the match and enable settings ask for it;
    // leaving that pair clears it, so a later return starts from zero.
    // Up counting restarts after each limit reach, giving a periodic flag.
    // Down counting arms on the first match and flags once, then waits
    // for the next match to re-arm; matches while armed are ignored.
    // A limit of zero or one flags at the first unit step.
    reg [4:0] us_div_reg;
    reg [9:0] ms_div_reg;
    reg [10:0] cnt_reg;
    reg armed_reg;
    wire us_tick = (us_div_reg == `AAR_US_CYCLES);
    wire ms_tick = us_tick && (ms_div_reg == `AAR_MS_US);
    wire unit_tick = map_byte_reg[`AAR_UNIT_BIT] ? ms_tick : us_tick;
    wire count_up = map_byte_reg[`AAR_DIR_BIT];

    // Free time base: 20 cycles per microsecond, 1000 us per millisecond
    // One shared base keeps area low; the cost is up to one unit of jitter
    // on the first down-count step after arming
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            us_div_reg <= `AAR_US_DIV_RST;
            ms_div_reg <= `AAR_MS_DIV_RST;
        end
        else
        begin
            us_div_reg <= us_tick ? `AAR_US_DIV_RST : us_div_reg + `AAR_US_DIV_ONE;
            if (us_tick)
                ms_div_reg <= (ms_div_reg == `AAR_MS_US) ? `AAR_MS_DIV_RST
                    : ms_div_reg + `AAR_MS_DIV_ONE;
        end
    end

    // Down count starts at the first match; up count counts matches
    // The flag is a one-cycle pulse; downstream must catch it on the edge
    always @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cnt_reg <= `AAR_CNT_ZERO;
            armed_reg <= 1'b0;
            o_count_event <= 1'b0;
        end
        else
        begin
            o_count_event <= 1'b0;
            if (!counter_use)
            begin
                cnt_reg <= `AAR_CNT_ZERO;
                armed_reg <= 1'b0;
            end
            else if (count_up)
            begin
                armed_reg <= 1'b0;
                if (i_match)
                begin
                    if (aar_step_up(cnt_reg) >= cnt_limit)
                    begin
                        o_count_event <= 1'b1;
                        cnt_reg <= `AAR_CNT_ZERO;
                    end
                    else
                        cnt_reg <= aar_step_up(cnt_reg);
                end
            end
            else if (!armed_reg)
            begin
                if (i_match)
                begin
                    cnt_reg <= cnt_limit;
                    armed_reg <= 1'b1;
                end
            end
            else if (unit_tick)
            begin
                if (cnt_reg <= `AAR_CNT_ONE)
                begin
                    o_count_event <= 1'b1;
                    armed_reg <= 1'b0;
                    cnt_reg <= `AAR_CNT_ZERO;
                end
                else
                    cnt_reg <= aar_step_down(cnt_reg);
            end
        end
    end

endmodule // aar_action

`default_nettype wire

// File: design/aar_map.vh
// Purpose: Constants for the entry action and cascade bytes
// Assumes: Byte-wide indirect access through select, offset and data registers
// Notes: Included by the action block only
`ifndef AAR_MAP_VH
`define AAR_MAP_VH
`define AAR_SEL_TABLE_ACL 3'h2
`define AAR_DATA_ADDR 8'hA0
`define AAR_SEL_TBL_HI 7
`define AAR_SEL_TBL_LO 5
`define AAR_SEL_PORT_HI 3
`define AAR_SEL_PORT_LO 0
`define AAR_OFF_PAGE_HI 7
`define AAR_OFF_PAGE_LO 4
`define AAR_OFF_PAGE_ZERO 4'h0
`define AAR_OFF_IDX_HI 3
`define AAR_OFF_IDX_LO 0
`define AAR_PRIO_RST 3'h0
`define AAR_RP_RST 2'h0
`define AAR_FWD_RST 5'h00
`define AAR_BITMAP_RST 16'h0000
`define AAR_US_DIV_RST 5'h00
`define AAR_US_DIV_ONE 5'h01
`define AAR_MS_DIV_RST 10'h000
`define AAR_MS_DIV_ONE 10'h001
`define AAR_OFF_PRIORITY 4'hA
`define AAR_OFF_PORT_MAP 4'hB
`define AAR_OFF_CASCADE_BITMAP_HI 4'hC
`define AAR_OFF_CASCADE_BITMAP_LO 4'hD
`define AAR_PM_HI 7
`define AAR_PM_LO 6
`define AAR_P_HI 5
`define AAR_P_LO 3
`define AAR_RPE_BIT 2
`define AAR_RP_HI 1
`define AAR_RP_LO 0
`define AAR_MM_HI 6
`define AAR_MM_LO 5
`define AAR_FWD_HI 4
`define AAR_FWD_LO 0
`define AAR_UNIT_BIT 4
`define AAR_DIR_BIT 3
`define AAR_PORT_MAP_MASK 8'h7F
`define AAR_BYTE_RST 8'h00
`define AAR_MODE_NONE 2'h0
`define AAR_MODE_HIGHER 2'h1
`define AAR_MODE_LOWER 2'h2
`define AAR_MODE_REPLACE 2'h3
`define AAR_MD_COUNTER 2'h1
`define AAR_ENB_COUNTER 2'h0
`define AAR_CNT_ZERO 11'h000
`define AAR_CNT_ONE 11'h001
`define AAR_US_CYCLES 5'h13
`define AAR_MS_US 10'h3E7
`endif
